/* File: rtl/mipwm_sequencer.sv */
// multiphase interleaved pwm sequencer top level
`timescale 1ns/1ns
module mipwm_sequencer
  import mipwm_pkg::*;
#(
  parameter int N_MAX    = mipwm_pkg::MAX_PHASES,
  parameter int W        = mipwm_pkg::PER_W,
  parameter int SOFT_CYC = 64
)
(
  input  wire logic              sys_clk,                     // system clock
  input  wire logic              srst,                        // sync reset, high
  input  wire logic [N_MAX-1:0]  strapIn,                     // pwm pins read as inputs
  input  wire logic [W-1:0]      switching_frequency,         // period in clock cycles
  input  wire logic [W-1:0]      dutyDemand,                  // trailing edge demand, cycles
  input  wire logic [RAMP_W-1:0] input_voltage_sense_pin,     // vin code, millivolts
  input  wire logic [RAMP_W-1:0] ramp_adjust_setting,         // ramp adjust code
  input  wire logic              all_phase_fire_on_step,      // large load step seen
  input  wire logic              dual_edge_pulse_positioning, // transient mode on
  input  wire logic [2:0]        shedCount,                   // requested phases, 0 = all
  input  wire logic              faultHold,                   // oc or ov fault
  output logic [2:0]             activePhases,                // latched phase count
  output logic [W-1:0]           rampSlope,                   // scaled up-ramp slope
  output logic                   running,                     // switching allowed
  output mipwm_pkg::mipwm_lvl_t  pwmLevel [N_MAX]             // per channel level
);
  import mipwm_pkg::*;

  mipwm_st_t  state;
  logic [7:0] waitCnt;
  logic [W-1:0] cycCnt;
  logic [2:0] runPhases;
  logic [2:0] slotIdx;
  logic [W-1:0] slotCnt;
  logic [2:0] rrIdx;
  logic [N_MAX-1:0] leadEv;
  logic [N_MAX-1:0] trailEv;
  logic [N_MAX-1:0] pulseOn;

  // first strapped pin gives the count; none strapped means the maximum
  function automatic logic [2:0] strap_count(input logic [N_MAX-1:0] s);
    logic [2:0] n;
    n = 3'(N_MAX);
    for (int i = N_MAX - 1; i >= 0; i--)
      if (s[i])
        n = 3'(i);
    return n;
  endfunction

  // slot length is the period split evenly over the active phases
  function automatic logic [W-1:0] slot_len(input logic [W-1:0] per, input logic [2:0] n);
    return (n == 3'h0) ? per : W'(per / n);
  endfunction

  wire logic [2:0]   strapPhases = strap_count(strapIn);
  wire logic [W-1:0] slotLen     = slot_len(switching_frequency, runPhases);
  wire logic         slotEnd     = (slotCnt >= slotLen - W'(1));
  wire logic         lastSlot    = (slotIdx >= runPhases - 3'h1);
  wire logic         cycleEnd    = slotEnd && lastSlot;
  wire logic [2:0]   reqPhases   = (shedCount == 3'h0 || shedCount > activePhases)
                                   ? activePhases : shedCount;
  wire logic [W-1:0] trailPoint  = (dutyDemand >= slotLen) ? slotLen - W'(1) : dutyDemand;
  wire logic         softDone    = (waitCnt == 8'(SOFT_CYC));
  wire logic [2*RAMP_W-1:0] rampProd = input_voltage_sense_pin * ramp_adjust_setting;

  assign running = (state == MIPWM_ST_RUN) && (activePhases != 3'h0);

  // strap capture once after reset, then soft-start delay, then run
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      state        <= MIPWM_ST_STRAP;
      waitCnt      <= 8'h00;
      activePhases <= PH_RST;
    end
    else
    begin
      unique case (state)
        MIPWM_ST_STRAP:
        begin
          waitCnt <= waitCnt + 8'h01;
          if (waitCnt == 8'(STRAP_WAIT_CYC))
          begin
            activePhases <= strapPhases;
            waitCnt      <= 8'h00;
            state        <= MIPWM_ST_SOFT;
          end
        end
        MIPWM_ST_SOFT:
        begin
          waitCnt <= waitCnt + 8'h01;
          if (softDone)
            state <= MIPWM_ST_RUN;
        end
        MIPWM_ST_RUN:
          state <= MIPWM_ST_RUN;
      endcase
    end
  end

  // slot timer: each channel owns one slot, slots repeat every period
  always_ff @(posedge sys_clk)
  begin
    if (srst || !running)
    begin
      slotCnt   <= '0;
      slotIdx   <= 3'h0;
      cycCnt    <= '0;
      runPhases <= activePhases;
    end
    else if (slotEnd)
    begin
      slotCnt <= '0;
      cycCnt  <= cycleEnd ? '0 : cycCnt + W'(1);
      slotIdx <= lastSlot ? 3'h0 : slotIdx + 3'h1;
      if (cycleEnd)
        runPhases <= reqPhases;
    end
    else
      slotCnt <= slotCnt + W'(1);
  end

  // round robin pointer spreads extra transient pulses over phases
  always_ff @(posedge sys_clk)
  begin
    if (srst || !running)
      rrIdx <= 3'h0;
    else if (dual_edge_pulse_positioning && !all_phase_fire_on_step && slotCnt == trailPoint)
      rrIdx <= (rrIdx >= runPhases - 3'h1) ? 3'h0 : rrIdx + 3'h1;
  end

  // ramp feed-forward: vin over the 12 V reference times adjust
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      rampSlope <= '0;
    else
      rampSlope <= W'(rampProd / (2*RAMP_W)'(VIN_REF_MV));
  end

  // edge events per channel: lead at slot start, trail at the demand point
  always_comb
  begin
    leadEv  = '0;
    trailEv = '0;
    for (int i = 0; i < N_MAX; i++)
    begin
      if (running && 3'(i) < runPhases)
      begin
        if (all_phase_fire_on_step)
          leadEv[i] = 1'b1;
        else if (dual_edge_pulse_positioning && 3'(i) == rrIdx && slotCnt == '0)
          leadEv[i] = 1'b1;
        else if (slotIdx == 3'(i) && slotCnt == '0)
          leadEv[i] = 1'b1;
        // trailing edge ends one slot after the previous channel's
        if (!all_phase_fire_on_step && slotIdx == 3'(i) && slotCnt == trailPoint)
          trailEv[i] = 1'b1;
      end
    end
  end

  // channels; shed channels sit at mid level while running, channels beyond the strapped count go low
  for (genvar g = 0; g < N_MAX; g++)
  begin : gCh
    wire logic shedMid = running && (3'(g) >= runPhases) && (3'(g) < activePhases);
    wire logic midNow  = (state == MIPWM_ST_SOFT) || faultHold || shedMid;
    mipwm_channel #(.W(W)) uCh (
      .sys_clk (sys_clk),
      .srst    (srst),
      .enable  (running && 3'(g) < runPhases),
      .midHold (midNow),
      .lead    (leadEv[g]),
      .trail   (trailEv[g]),
      .pulseOn (pulseOn[g]),
      .level   (pwmLevel[g])
    );
  end

  // no switching at all when zero phases strapped: channel one never goes high
  zero_off_a: assert property (@(posedge sys_clk) disable iff (srst)
    (state == MIPWM_ST_RUN && activePhases == 3'h0) |=> (pwmLevel[0] != MIPWM_OUT_HIGH))
    else $error("switching with zero phases");
  // slot counter and slot index advance together, so spacing stays even
  slot_count_a: assert property (@(posedge sys_clk) disable iff (srst)
    running |-> (cycCnt == W'(slotIdx))) else $error("slot count drift");
  // a fault pulls the outputs to mid level on the next edge
  fault_mid_a: assert property (@(posedge sys_clk) disable iff (srst)
    faultHold |=> (pwmLevel[0] == MIPWM_OUT_MID)) else $error("fault not mid");
  // channels beyond the strapped count stay low once running with no fault; a fault holds them at mid level
  unused_low_a: assert property (@(posedge sys_clk) disable iff (srst)
    (state == MIPWM_ST_RUN && !faultHold && activePhases < 3'h6)
    |=> (pwmLevel[5] == MIPWM_OUT_LOW)) else $error("unused channel moved");
  // in steady state channel one leads at the start of its own slot
  lead_slot_a: assert property (@(posedge sys_clk) disable iff (srst)
    (running && !all_phase_fire_on_step && slotIdx == 3'h0 && slotCnt == '0
     && runPhases != 3'h0) |-> leadEv[0]) else $error("missing lead edge");
  strap_latch_a: assert property (@(posedge sys_clk) disable iff (srst)
    (state == MIPWM_ST_RUN) |-> $stable(activePhases)) else $error("phase count moved");
  order_step_a: assert property (@(posedge sys_clk) disable iff (srst)
    (running && slotEnd && !lastSlot) |=> (slotIdx == $past(slotIdx) + 3'h1))
    else $error("slot order broken");
  wrap_a: assert property (@(posedge sys_clk) disable iff (srst)
    (running && cycleEnd) |=> (slotIdx == 3'h0)) else $error("no wrap to one");
  shed_next_a: assert property (@(posedge sys_clk) disable iff (srst)
    (running && !cycleEnd) |=> $stable(runPhases)) else $error("shed mid cycle");
  all_fire_a: assert property (@(posedge sys_clk) disable iff (srst)
    (running && all_phase_fire_on_step && runPhases != 3'h0) |-> leadEv[0])
    else $error("step did not fire");
  soft_mid_a: assert property (@(posedge sys_clk) disable iff (srst)
    (state == MIPWM_ST_SOFT) |=> (pwmLevel[0] == MIPWM_OUT_MID))
    else $error("soft start not mid");
  limit_a: assert property (@(posedge sys_clk) disable iff (srst)
    running |-> (runPhases <= activePhases)) else $error("too many phases");
  trail_one_a: assert property (@(posedge sys_clk) disable iff (srst)
    $onehot0(trailEv)) else $error("two trailing edges");
  cover_six_c: cover property (@(posedge sys_clk) running && activePhases == 3'h6 && cycleEnd);
  cover_step_c: cover property (@(posedge sys_clk) running && all_phase_fire_on_step);
  cover_shed_c: cover property (@(posedge sys_clk) running && runPhases < activePhases);
  cover_five_c: cover property (@(posedge sys_clk) running && activePhases == 3'h5 && cycleEnd);
  cover_depp_c: cover property (@(posedge sys_clk) running && dual_edge_pulse_positioning);
endmodule

/* File: rtl/mipwm_pkg.sv */
// package for the multiphase interleaved pwm sequencer
package mipwm_pkg;
  localparam int MAX_PHASES      = 6;
  localparam int PER_W           = 16;
  localparam int RAMP_W          = 12;
  localparam int SYS_CLK_HZ      = 50_000_000;
  localparam int FSW_HZ_DEFAULT  = 500_000;
  // cycles per switching period, derived from rate and frequency
  localparam int PERIOD_CYC_DEF  = SYS_CLK_HZ / FSW_HZ_DEFAULT;
  // input sense reference: 12 V expressed in the sense code scale
  localparam int VIN_REF_MV      = 12_000;
  localparam int STRAP_WAIT_CYC  = 4;
  localparam logic [2:0] PH_RST  = 3'h6;
  typedef enum logic [1:0] {MIPWM_OUT_LOW, MIPWM_OUT_HIGH, MIPWM_OUT_MID} mipwm_lvl_t;
  typedef enum logic [1:0] {MIPWM_ST_STRAP, MIPWM_ST_SOFT, MIPWM_ST_RUN} mipwm_st_t;
endpackage

/* File: rtl/mipwm_channel.sv */
// one pwm channel: leading and trailing edge comparator with level coding
`timescale 1ns/1ns
module mipwm_channel
  import mipwm_pkg::*;
#(
  parameter int W = mipwm_pkg::PER_W
)
(
  input  wire logic         sys_clk,   // system clock
  input  wire logic         srst,      // sync reset, high
  input  wire logic         enable,    // channel may switch
  input  wire logic         midHold,   // force tri-state level
  input  wire logic         lead,      // leading edge event
  input  wire logic         trail,     // trailing edge event
  output logic              pulseOn,   // pulse state
  output mipwm_pkg::mipwm_lvl_t level  // output level code
);
  // pulse set on leading edge, cleared on trailing; trailing wins to avoid runaway on
  always_ff @(posedge sys_clk)
  begin
    if (srst || !enable || midHold)
      pulseOn <= 1'b0;
    else if (trail)
      pulseOn <= 1'b0;
    else if (lead)
      pulseOn <= 1'b1;
  end

  // registered level so the output is glitch free
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      level <= MIPWM_OUT_MID;
    else if (midHold)
      level <= MIPWM_OUT_MID;
    else if (!enable)
      level <= MIPWM_OUT_LOW;
    else if (trail)
      level <= MIPWM_OUT_LOW;
    else if (lead || pulseOn)
      level <= MIPWM_OUT_HIGH;
    else
      level <= MIPWM_OUT_LOW;
  end
endmodule

/* File: tb/mipwm_driver_model.sv */
// power-stage model: board straps plus edge timestamps for each phase
`timescale 1ns/1ns
module mipwm_driver_model
  import mipwm_pkg::*;
(
  input  wire logic                 sys_clk,      // system clock
  input  wire logic                 srst,         // clears the turn-on counts
  input  wire logic [2:0]           strapPhases,  // phase count set by the board
  input  wire mipwm_pkg::mipwm_lvl_t pwmLevel [6], // levels from the controller
  output logic [5:0]                strapIn,      // pins tied to the supply
  output int                        riseAt [6],   // cycle of last turn-on
  output int                        fallAt [6],   // cycle of last turn-off
  output int                        prevFall [6], // turn-off before that
  output int                        riseCnt [6]   // turn-ons seen
);
  import mipwm_pkg::*;
  int         cyc;
  mipwm_lvl_t lastLvl [6];
  // pin n+1 tied high selects n phases; six phases need no tie
  assign strapIn = (strapPhases < 3'h6) ? (6'h01 << strapPhases) : 6'h00;
  // mid level and low both release the gates, so only high counts as on
  always_ff @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    for (int i = 0; i < 6; i++)
    begin
      lastLvl[i] <= srst ? MIPWM_OUT_LOW : pwmLevel[i];
      if (srst)
        riseCnt[i] <= 0;
      else if (pwmLevel[i] == MIPWM_OUT_HIGH && lastLvl[i] != MIPWM_OUT_HIGH)
      begin
        riseAt[i]  <= cyc;
        riseCnt[i] <= riseCnt[i] + 1;
      end
      if (!srst && lastLvl[i] == MIPWM_OUT_HIGH && pwmLevel[i] != MIPWM_OUT_HIGH)
      begin
        fallAt[i]   <= cyc;
        prevFall[i] <= fallAt[i];
      end
    end
  end
endmodule

/* File: tb/mipwm_sequencer_tb.sv */
// self-checking bench for the multiphase sequencer
`timescale 1ns/1ns
module mipwm_sequencer_tb;
  import mipwm_pkg::*;
  localparam int P = 120;
  logic       sys_clk, srst, apf, depp, faultHold;
  logic [2:0] strapPhases, shedCount, activePhases;
  logic [5:0] strapIn;
  logic [11:0] vin, adj;
  logic [15:0] rampSlope;
  logic       running;
  mipwm_lvl_t pwmLevel [6];
  int         riseAt [6], fallAt [6], prevFall [6], riseCnt [6];
  int         n_mismatch, n_compared;
  int         baseCnt [3];

  mipwm_sequencer #(.SOFT_CYC(8)) mipwm_sequencer_i (.sys_clk(sys_clk), .srst(srst),
    .strapIn(strapIn), .switching_frequency(16'h0078), .dutyDemand(16'h0005),
    .input_voltage_sense_pin(vin), .ramp_adjust_setting(adj),
    .all_phase_fire_on_step(apf), .dual_edge_pulse_positioning(depp),
    .shedCount(shedCount), .faultHold(faultHold), .activePhases(activePhases),
    .rampSlope(rampSlope), .running(running), .pwmLevel(pwmLevel));
  mipwm_driver_model mipwm_driver_model_i (.sys_clk(sys_clk), .srst(srst),
    .strapPhases(strapPhases), .pwmLevel(pwmLevel), .strapIn(strapIn),
    .riseAt(riseAt), .fallAt(fallAt), .prevFall(prevFall), .riseCnt(riseCnt));

  // free-running 50 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic final_report();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // bounded wait for a fresh turn-on of one channel
  task automatic wait_rise(input int ch);
    int c0;
    c0 = riseCnt[ch];
    for (int i = 0; i <= 4 * P; i++)
    begin
      @(negedge sys_clk);
      if (riseCnt[ch] != c0)
        return;
    end
    n_mismatch++;
    final_report();
  endtask

  // reset with a strap setting, then judge order and spacing of edges
  task automatic phase_test(input int n);
    strapPhases = n[2:0];
    srst = 1'b1;
    repeat (10) @(negedge sys_clk);
    srst = 1'b0;
    repeat (200) @(negedge sys_clk);
    chk(activePhases, n);
    chk(running, n != 0);
    if (n > 0)
    begin
      repeat (3 * P) @(negedge sys_clk);
      wait_rise(n - 1);
      for (int k = 1; k < n; k++)
        chk(riseAt[k] - riseAt[k - 1], P / n);
      for (int k = 1; k < n - 1; k++)
        chk(fallAt[k] - fallAt[k - 1], P / n);
      chk(fallAt[0] - prevFall[0], P);
    end
    for (int j = n; j < 6; j++)
      chk(riseCnt[j], 0);
  endtask

  // main sequence: strap counts 6, 5, 3, 1 and 0, with shed, fault, step, transient and ramp checks between
  initial
  begin
    srst = 1'b1; apf = 1'b0; depp = 1'b0; faultHold = 1'b0;
    strapPhases = 3'h6; shedCount = 3'h0; vin = 12'h0bb8; adj = 12'h0190;
    n_mismatch = 0; n_compared = 0;
    phase_test(6);
    chk(rampSlope, 100);
    shedCount = 3'h2;
    repeat (3 * P) @(negedge sys_clk);
    for (int j = 2; j < 6; j++)
      chk(pwmLevel[j], MIPWM_OUT_MID);
    faultHold = 1'b1;
    repeat (2) @(negedge sys_clk);
    for (int j = 0; j < 6; j++)
      chk(pwmLevel[j], MIPWM_OUT_MID);
    faultHold = 1'b0; shedCount = 3'h0; vin = 12'h0fa0; adj = 12'h003c;
    phase_test(5);
    chk(rampSlope, 20);
    phase_test(3);
    apf = 1'b1;
    repeat (2 * P) @(negedge sys_clk);
    for (int j = 0; j < 3; j++)
      chk(pwmLevel[j], MIPWM_OUT_HIGH);
    // transient mode: channel one must pulse, and no other phase may gain more than one pulse over it
    apf = 1'b0;
    depp = 1'b1;
    for (int j = 0; j < 3; j++)
      baseCnt[j] = riseCnt[j];
    repeat (6 * P) @(negedge sys_clk);
    chk(riseCnt[0] != baseCnt[0], 1);
    for (int j = 1; j < 3; j++)
      chk((riseCnt[j] - baseCnt[j]) - (riseCnt[0] - baseCnt[0]) + 1 <= 2, 1);
    depp = 1'b0;
    phase_test(1);
    phase_test(0);
    final_report();
  end
endmodule
